// ===== src/slp_ctrl.sv
// sleep-mode controller: sleep entry, wake-up, watchdog and apb registers
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module slp_ctrl #(
    parameter int NUM_IRQ = 8
) (
    input  wire logic               clk,               // 40 mhz system clock
    input  wire logic               rst_n,             // synchronous reset, active low
    input  wire logic               psel,              // apb select
    input  wire logic               penable,           // apb access phase
    input  wire logic               pwrite,            // apb write
    input  wire logic [7:0]         paddr,             // apb byte address
    input  wire logic [31:0]        pwdata,            // apb write data
    output logic [31:0]             prdata,            // apb read data
    output logic                    pready,            // apb ready
    output logic                    pslverr,           // apb error, unmapped address
    input  wire logic               sleep_instr,       // core executes sleep, one pulse
    input  wire logic               watchdog_clear_instr, // core executes clear, one pulse
    input  wire logic               global_irq_enable, // core global enable
    input  wire logic [NUM_IRQ-1:0] irq_flags,         // interrupt flags incl. external
    input  wire logic [NUM_IRQ-1:0] irq_enables,       // individual enables
    input  wire logic [1:0]         wdt_config,        // watchdog config mode
    input  wire logic               crystal_mode,      // crystal or resonator clock
    input  wire logic               two_speed_start,   // two-speed start-up enabled
    input  wire logic [1:0]         timer1_src,        // secondary timer clock source
    input  wire logic               adc_rc_select,     // converter_rc_clock selected
    input  wire logic               ext_reset_pin_n,   // external_reset_pin, async, low
    input  wire logic               brownout_reset,    // brownout_reset event, async
    input  wire logic               por_event,         // power-on reset event, async
    output logic                    cpu_clk_en,        // cpu clock gate
    output logic                    lf_osc_run,        // low_freq_internal_osc running
    output logic                    timer1_run,        // secondary timer clock allowed
    output logic                    adc_run,           // converter allowed to run
    output logic                    io_hold,           // latch i/o drive state
    output logic                    regulator_lp,      // regulator in low power
    output logic                    sleep_nop,         // sleep taken as nop, pulse
    output logic                    wake_done,         // resume after wake, pulse
    output logic                    isr_call,          // call isr after pc+1, pulse
    output logic [15:0]             isr_vector,        // isr address for isr_call
    output logic                    device_reset,      // device reset request, pulse
    output logic                    power_down_flag,   // status copy
    output logic                    timeout_flag       // status copy
);
    typedef struct packed {
        slp_pkg::slp_state_e state;
        logic        to;
        logic        pd;
        logic        vreg_lp;
        logic        vreg_rsvd;
        logic [4:0]  wdt_ps;
        logic        wdt_en;
        logic [23:0] wdt_cnt;
        logic [10:0] lf_div;
        logic [15:0] dly;
        logic        irq_wake;
        logic [2:0]  s1;
        logic [2:0]  s2;
        logic [2:0]  s3;
        logic [2:0]  stable;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        cpu_clk_en;
        logic        lf_osc_run;
        logic        timer1_run;
        logic        adc_run;
        logic        io_hold;
        logic        regulator_lp;
        logic        sleep_nop;
        logic        wake_done;
        logic        isr_call;
        logic [15:0] isr_vector;
        logic        device_reset;
    } slp_regs_s;

    slp_regs_s r_reg;
    slp_regs_s r_next;

    // watchdog terminal count for a period select code
    function automatic logic [23:0] wdt_period(input logic [4:0] ps);
        logic [4:0] sel;
        sel = (ps > slp_pkg::WDT_PS_MAX) ? 5'h00 : ps;
        return 24'h000001 << (5'(slp_pkg::WDT_MIN_SHIFT) + sel);
    endfunction

    // watchdog active for the config mode and sleep state
    function automatic logic wdt_active(input logic [1:0] cfg, input logic sw_en, input logic asleep);
        case (cfg)
            slp_pkg::WDTE_ON:    return 1'b1;
            slp_pkg::WDTE_NOSLP: return !asleep;
            slp_pkg::WDTE_SW:    return sw_en;
            default:             return 1'b0;
        endcase
    endfunction

    logic        asleep;
    logic        irq_pend;
    logic        lf_tick;
    logic        wdt_on;
    logic        wdt_expire;
    logic [2:0]  pin_level;
    logic [2:0]  pin_rise;
    logic        rst_evt;
    logic        apb_done;
    logic [15:0] wake_dly;

    always_comb begin
        asleep     = (r_reg.state != slp_pkg::ST_RUN);
        irq_pend   = |(irq_flags & irq_enables); // [R10]
        lf_tick    = (r_reg.lf_div == 11'(slp_pkg::LF_TICK_CYCLES - 1));
        wdt_on     = wdt_active(wdt_config, r_reg.wdt_en, asleep);
        wdt_expire = wdt_on && lf_tick && (r_reg.wdt_cnt == wdt_period(r_reg.wdt_ps) - 24'h000001); // [R21]
        pin_level  = {!ext_reset_pin_n, brownout_reset, por_event};
        // a pin going active counts once the second and third stages agree
        pin_rise   = (r_reg.s2 ~^ r_reg.s3) & r_reg.s3 & ~r_reg.stable;
        rst_evt    = |pin_rise;
        apb_done   = psel && penable && r_reg.pready;
        // delays summed: oscillator start-up then regulator settle
        wake_dly   = ((crystal_mode && !two_speed_start) ? 16'(slp_pkg::OST_CYCLES) : 16'h0000) // [R16]
                   + (r_reg.vreg_lp ? 16'(slp_pkg::REG_STAB_CYCLES) : 16'h0000);             // [R18]
    end

    // next state of the whole block
    always_comb begin
        r_next              = r_reg;
        r_next.sleep_nop    = 1'b0;
        r_next.wake_done    = 1'b0;
        r_next.isr_call     = 1'b0;
        r_next.device_reset = 1'b0;
        r_next.pready       = 1'b0;
        r_next.pslverr      = 1'b0;

        // three-stage pin synchronisers
        r_next.s1 = pin_level;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        for (int i = 0; i < 3; i++) begin
            if (r_reg.s2[i] == r_reg.s3[i]) begin
                r_next.stable[i] = r_reg.s3[i];
            end
        end

        // free-running low frequency time base, never gated by sleep
        r_next.lf_div     = lf_tick ? 11'h000 : r_reg.lf_div + 11'h001;
        r_next.lf_osc_run = 1'b1; // [R4]

        // watchdog count; held clear while disabled
        if (!wdt_on) begin
            r_next.wdt_cnt = 24'h000000;
        end else if (lf_tick) begin
            r_next.wdt_cnt = wdt_expire ? 24'h000000 : r_reg.wdt_cnt + 24'h000001;
        end
        if (watchdog_clear_instr && r_reg.state == slp_pkg::ST_RUN) begin
            r_next.wdt_cnt = 24'h000000;
            r_next.to      = 1'b1;
            r_next.pd      = 1'b1;
        end

        case (r_reg.state)
            slp_pkg::ST_RUN: begin
                if (wdt_expire) begin
                    r_next.device_reset = 1'b1; // [R20]
                    r_next.to           = 1'b0;
                    r_next.pd           = 1'b1;
                end else if (sleep_instr) begin // [R1]
                    if (!global_irq_enable && irq_pend) begin
                        // flags and watchdog untouched so software can tell via pd
                        r_next.sleep_nop = 1'b1; // [R14]
                    end else begin
                        r_next.state      = slp_pkg::ST_SLEEP;
                        r_next.wdt_cnt    = 24'h000000; // [R2]
                        r_next.pd         = 1'b0;       // [R3]
                        r_next.to         = 1'b1;       // [R3]
                        r_next.cpu_clk_en = 1'b0;       // [R4]
                        r_next.io_hold    = 1'b1;       // [R7]
                    end
                end
            end
            slp_pkg::ST_SLEEP: begin
                // irq already pending at entry wakes on the very next cycle
                if (irq_pend || wdt_expire) begin // [R9] [R15]
                    r_next.state    = slp_pkg::ST_WAKE;
                    r_next.irq_wake = irq_pend;
                    r_next.dly      = wake_dly;
                    r_next.wdt_cnt  = 24'h000000; // [R13]
                    if (!irq_pend) begin
                        r_next.to = 1'b0; // [R22]
                        r_next.pd = 1'b0;
                    end
                end
            end
            slp_pkg::ST_WAKE: begin
                r_next.wdt_cnt = 24'h000000; // held clear until start-up ends
                if (r_reg.dly == 16'h0000) begin
                    r_next.state      = slp_pkg::ST_RUN;
                    r_next.cpu_clk_en = 1'b1; // [R23]
                    r_next.io_hold    = 1'b0;
                    r_next.wake_done  = 1'b1; // [R22]
                    if (r_reg.irq_wake && global_irq_enable) begin
                        r_next.isr_call   = 1'b1;                 // [R11]
                        r_next.isr_vector = slp_pkg::ISR_VECTOR;  // [R12]
                    end
                end else begin
                    r_next.dly = r_reg.dly - 16'h0001;
                end
            end
            default: begin
                r_next.state = slp_pkg::ST_RUN;
            end
        endcase

        // pin resets act in every state and win over sleep handling
        if (rst_evt) begin // [R8] [R9]
            r_next.state        = slp_pkg::ST_RUN;
            r_next.device_reset = 1'b1;
            r_next.cpu_clk_en   = 1'b1;
            r_next.io_hold      = 1'b0;
            r_next.wdt_cnt      = 24'h000000;
            if (pin_rise[0]) begin
                r_next.to = slp_pkg::RST_TIMEOUT;
                r_next.pd = slp_pkg::RST_POWERDOWN;
            end
        end

        // peripheral run permissions follow the state being entered
        r_next.timer1_run   = (r_next.state == slp_pkg::ST_RUN) || (timer1_src != slp_pkg::T1_SRC_SYS); // [R5]
        r_next.adc_run      = (r_next.state == slp_pkg::ST_RUN) || adc_rc_select;                      // [R6]
        r_next.regulator_lp = (r_next.state == slp_pkg::ST_SLEEP) && r_reg.vreg_lp;                    // [R17]

        // apb slave: ready one cycle into the access phase
        if (psel && penable && !r_reg.pready) begin
            r_next.pready = 1'b1;
            r_next.prdata = 32'h00000000;
            case (paddr)
                slp_pkg::ADDR_CORE_STATUS: begin
                    r_next.prdata[slp_pkg::STAT_TIMEOUT_BIT]   = r_reg.to;
                    r_next.prdata[slp_pkg::STAT_POWERDOWN_BIT] = r_reg.pd;
                end
                slp_pkg::ADDR_REGULATOR_CONTROL: begin
                    r_next.prdata[slp_pkg::VREG_LP_BIT]   = r_reg.vreg_lp;
                    r_next.prdata[slp_pkg::VREG_RSVD_BIT] = r_reg.vreg_rsvd;
                end
                slp_pkg::ADDR_WATCHDOG_CONTROL: begin
                    r_next.prdata[slp_pkg::WDT_PS_LSB +: 5] = r_reg.wdt_ps;
                    r_next.prdata[slp_pkg::WDT_EN_BIT]      = r_reg.wdt_en;
                end
                default: begin
                    r_next.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_done && pwrite) begin
            case (paddr)
                slp_pkg::ADDR_REGULATOR_CONTROL: begin
                    r_next.vreg_lp   = pwdata[slp_pkg::VREG_LP_BIT];
                    r_next.vreg_rsvd = pwdata[slp_pkg::VREG_RSVD_BIT]; // [R19]
                end
                slp_pkg::ADDR_WATCHDOG_CONTROL: begin
                    r_next.wdt_ps = pwdata[slp_pkg::WDT_PS_LSB +: 5];
                    r_next.wdt_en = pwdata[slp_pkg::WDT_EN_BIT];
                end
                default: begin
                    // status flags are read-only to software
                end
            endcase
        end
    end

    // single register stage; reset brings the block up awake
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg              <= '0;
            r_reg.state        <= slp_pkg::ST_RUN;
            r_reg.to           <= slp_pkg::RST_TIMEOUT;
            r_reg.pd           <= slp_pkg::RST_POWERDOWN;
            r_reg.vreg_lp      <= slp_pkg::RST_VREG_LP;
            r_reg.vreg_rsvd    <= slp_pkg::RST_VREG_RSVD;
            r_reg.wdt_ps       <= slp_pkg::RST_WDT_PS;
            r_reg.wdt_en       <= slp_pkg::RST_WDT_EN;
            r_reg.cpu_clk_en   <= 1'b1;
            r_reg.lf_osc_run   <= 1'b1;
            r_reg.timer1_run   <= 1'b1;
            r_reg.adc_run      <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // outputs straight from flops
    assign prdata          = r_reg.prdata;
    assign pready          = r_reg.pready;
    assign pslverr         = r_reg.pslverr;
    assign cpu_clk_en      = r_reg.cpu_clk_en;
    assign lf_osc_run      = r_reg.lf_osc_run;
    assign timer1_run      = r_reg.timer1_run;
    assign adc_run         = r_reg.adc_run;
    assign io_hold         = r_reg.io_hold;
    assign regulator_lp    = r_reg.regulator_lp;
    assign sleep_nop       = r_reg.sleep_nop;
    assign wake_done       = r_reg.wake_done;
    assign isr_call        = r_reg.isr_call;
    assign isr_vector      = r_reg.isr_vector;
    assign device_reset    = r_reg.device_reset;
    assign power_down_flag = r_reg.pd;
    assign timeout_flag    = r_reg.to;
endmodule // slp_ctrl

// ===== src/slp_pkg.sv
// package for the sleep-mode controller: map, fields, reset values and timing
// Functional notes
// [R1] power-down is entered only by the core's sleep instruction pulse
// [R2] entering sleep clears the watchdog; it keeps counting if active in sleep
// [R3] entering sleep clears power_down_flag and sets timeout_flag
// [R4] cpu clock stops in sleep; low_freq_internal_osc keeps running
// [R5] secondary timer runs in sleep on lf osc, ext clock or secondary osc
// [R6] converter runs in sleep when converter_rc_clock is selected
// [R7] i/o pins hold their pre-sleep drive state while asleep
// [R8] reset sources other than the watchdog act the same asleep or awake
// [R9] wake on pin, brownout, power-on reset, watchdog, external or peripheral irq
// [R10] an interrupt wakes only if individually enabled, whatever global_irq_enable
// [R11] irq wake: gie clear continues at pc+1; gie set runs pc+1 then isr
// [R12] gie set irq wake vectors the core to address 0004h
// [R13] every wake from sleep clears the watchdog
// [R14] gie clear and enabled flag pending: sleep is a nop, flags untouched
// [R15] irq during or after sleep: complete sleep, wake at once, flags updated
// [R16] crystal mode wake waits 1024 osc periods unless two-speed start-up
// [R17] regulator_low_power_select puts regulator in low power during sleep
// [R18] low-power regulator sleep adds a stabilisation delay on wake
// [R19] software always writes one to the reserved regulator bit 0
// [R20] watchdog resets the device if not cleared within the period
// [R21] watchdog period selectable from 1 ms to 256 s nominal
// [R22] watchdog time-out in sleep wakes and resumes, flags record it
// [R23] cpu clock re-enabled only after start-up and stabilisation delays
package slp_pkg;
    // register byte addresses on the apb
    localparam logic [7:0] ADDR_CORE_STATUS       = 8'h00;
    localparam logic [7:0] ADDR_REGULATOR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_WATCHDOG_CONTROL  = 8'h08;
    // field positions
    localparam int STAT_TIMEOUT_BIT   = 4;
    localparam int STAT_POWERDOWN_BIT = 3;
    localparam int VREG_LP_BIT        = 1;
    localparam int VREG_RSVD_BIT      = 0;
    localparam int WDT_PS_LSB         = 1;
    localparam int WDT_EN_BIT         = 0;
    // reset values
    localparam logic       RST_TIMEOUT   = 1'b1;
    localparam logic       RST_POWERDOWN = 1'b1;
    localparam logic       RST_VREG_LP   = 1'b0;
    localparam logic       RST_VREG_RSVD = 1'b1;
    localparam logic [4:0] RST_WDT_PS    = 5'h0B;
    localparam logic       RST_WDT_EN    = 1'b0;
    // watchdog period select: 1:32 up to 1:2^23, codes above are minimum
    localparam logic [4:0] WDT_PS_MAX    = 5'h12;
    localparam int         WDT_MIN_SHIFT = 5;
    // isr vector
    localparam logic [15:0] ISR_VECTOR = 16'h0004;
    // timing
    localparam int CLK_HZ          = 40000000;
    localparam int LFOSC_HZ        = 31000;
    localparam int LF_TICK_CYCLES  = CLK_HZ / LFOSC_HZ;
    localparam int OST_OSC_PERIODS = 1024;
    localparam int OST_CYCLES      = OST_OSC_PERIODS;
    localparam int REG_STAB_NS     = 16000;
    localparam int REG_STAB_CYCLES = (REG_STAB_NS * (CLK_HZ / 1000000) + 999) / 1000;
    // secondary timer clock source encodings
    localparam logic [1:0] T1_SRC_SYS   = 2'h0;
    localparam logic [1:0] T1_SRC_LFOSC = 2'h1;
    localparam logic [1:0] T1_SRC_EXT   = 2'h2;
    localparam logic [1:0] T1_SRC_SOSC  = 2'h3;
    // watchdog config modes
    localparam logic [1:0] WDTE_OFF   = 2'h0;
    localparam logic [1:0] WDTE_SW    = 2'h1;
    localparam logic [1:0] WDTE_NOSLP = 2'h2;
    localparam logic [1:0] WDTE_ON    = 2'h3;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP,
        ST_WAKE
    } slp_state_e;
endpackage

// ===== sim/slp_ctrl_monitor.sv
// checks on the sleep controller ports
`timescale 1ns/1ps
module slp_ctrl_monitor #(
    parameter int NUM_IRQ = 8
) (
    input wire logic               clk,               // clock
    input wire logic               rst_n,             // sync reset
    input wire logic               psel,              // apb
    input wire logic               penable,           // apb
    input wire logic               pready,            // apb
    input wire logic               sleep_instr,       // core
    input wire logic               global_irq_enable, // core
    input wire logic [NUM_IRQ-1:0] irq_flags,         // core
    input wire logic [NUM_IRQ-1:0] irq_enables,       // core
    input wire logic               cpu_clk_en,        // gate
    input wire logic               io_hold,           // pins
    input wire logic               regulator_lp,      // ldo
    input wire logic               sleep_nop,         // pulse
    input wire logic               wake_done,         // pulse
    input wire logic               isr_call,          // pulse
    input wire logic [15:0]        isr_vector,        // isr
    input wire logic               power_down_flag,   // status
    input wire logic               timeout_flag       // status
);
    logic        pend;
    logic [10:0] wait_cnt;
    // enabled request, gie ignored
    assign pend = |(irq_flags & irq_enables);
    // cycles asleep with a request up, too many for a delay range
    always_ff @(posedge clk) begin
        wait_cnt <= (rst_n && io_hold && pend) ? wait_cnt + 11'h001 : 11'h000;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // sleep in run: taken, or a nop
    sequence s_go;
        sleep_instr && cpu_clk_en && (global_irq_enable || !pend);
    endsequence
    sequence s_skip;
        sleep_instr && cpu_clk_en && !global_irq_enable && pend;
    endsequence
    sequence s_asleep;
        !cpu_clk_en && io_hold && !power_down_flag && timeout_flag;
    endsequence
    a_sleep_entry: assert property (s_go |=> s_asleep) else $error("sleep entry state wrong");
    a_sleep_skip: assert property (s_skip |=> sleep_nop && cpu_clk_en && $stable(power_down_flag)
        && $stable(timeout_flag)) else $error("sleep not taken as nop");
    a_only_by_instr: assert property ($fell(cpu_clk_en) |-> $past(sleep_instr)) else $error("gate off w/o sleep");
    a_pins_held: assert property (io_hold != cpu_clk_en) else $error("pin hold not tied to sleep");
    a_wake_resume: assert property (wake_done |-> cpu_clk_en && !io_hold && $past(io_hold))
        else $error("resume without wake");
    a_isr_vec: assert property (isr_call |-> wake_done ##1 (isr_vector == 16'h0004 && !isr_call))
        else $error("isr call or vector wrong");
    a_reg_low: assert property (regulator_lp |-> io_hold && !cpu_clk_en) else $error("regulator low awake");
    a_wake_irq: assert property (wait_cnt < 11'h6A5)
        else $error("no wake on enabled irq");
    a_apb_ready: assert property (psel && penable && !pready |=> pready) else $error("apb answer late");
endmodule // slp_ctrl_monitor

bind slp_ctrl slp_ctrl_monitor #(.NUM_IRQ(NUM_IRQ)) i_slp_ctrl_monitor (.*);

// ===== sim/slp_core_model.sv
// processor-core stand-in: sleep and clear pulses, interrupt flags
`timescale 1ns/1ps
module slp_core_model #(
    parameter logic [7:0] EN_MASK = 8'h0F
) (
    input  wire logic       clk,                  // system clock
    input  wire logic       rst_n,                // sync reset, low
    input  wire logic       req_sleep,            // level from bench
    input  wire logic       req_clr,              // level from bench
    input  wire logic       irq_en_req,           // global enable wish
    input  wire logic [7:0] irq_req,              // raw interrupt events
    output logic            sleep_instr,          // one per request
    output logic            watchdog_clear_instr, // one per request
    output logic            global_irq_enable,    // core enable
    output logic [7:0]      irq_flags,            // pending flags
    output logic [7:0]      irq_enables           // fixed enables
);
    logic [1:0] seen_reg;
    // one pulse per request level
    always_ff @(posedge clk) begin
        seen_reg <= rst_n ? {req_sleep, req_clr} : 2'b00;
    end
    assign sleep_instr          = req_sleep & ~seen_reg[1];
    assign watchdog_clear_instr = req_clr & ~seen_reg[0];
    assign global_irq_enable    = irq_en_req;
    // flags rise whatever the enables say
    assign irq_flags            = irq_req;
    assign irq_enables          = EN_MASK;
endmodule // slp_core_model

// ===== sim/tb_slp_ctrl.sv
// self-checking bench for the sleep-mode controller
`timescale 1ns/1ps
module tb_slp_ctrl;
    // row: xt, two-speed, low-power, gie, timer1 source, rc clock
    typedef struct packed {logic xt; logic ts; logic lp; logic g; logic [1:0] src; logic arc;} slp_row_s;
    localparam slp_row_s ROWS [4] = '{7'b0000000, 7'b1001011, 7'b1110100, 7'b1011111};
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [7:0]  paddr = 8'h00, irq_req = 8'h00, irq_flags, irq_enables;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0]  wdt_config = 2'h0, timer1_src = 2'h0;
    logic        crystal_mode = 1'b0, two_speed_start = 1'b0, adc_rc_select = 1'b0;
    logic        ext_reset_pin_n = 1'b1, brownout_reset = 1'b0, por_event = 1'b0;
    logic        req_sleep = 1'b0, req_clr = 1'b0, irq_en_req = 1'b0;
    logic        pready, pslverr, sleep_instr, watchdog_clear_instr, global_irq_enable;
    logic        cpu_clk_en, lf_osc_run, timer1_run, adc_run, io_hold, regulator_lp;
    logic        sleep_nop, wake_done, isr_call, device_reset, power_down_flag, timeout_flag;
    logic [15:0] isr_vector;
    slp_row_s    r;
    int          err_total = 0, samples_checked = 0, c, d;

    always #12.5 clk = ~clk;

    slp_core_model i_slp_core_model (.clk, .rst_n, .req_sleep, .req_clr, .irq_en_req, .irq_req,
        .sleep_instr, .watchdog_clear_instr, .global_irq_enable, .irq_flags, .irq_enables);
    slp_ctrl #(.NUM_IRQ(8)) i_slp_ctrl (.*);

    task automatic print_verdict();
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer, opened on a fresh edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        int n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= dat;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
        end
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(er, err);
    endtask
    task automatic sleep_go();
        req_sleep <= 1'b1;
        @(posedge clk);
        req_sleep <= 1'b0;
        @(posedge clk);
    endtask
    // edges until the pulse, bounded
    task automatic wt(input logic rst_ev, input int lim);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while ((rst_ev ? device_reset : wake_done) !== 1'b1 && c < lim);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(slp_pkg::ADDR_CORE_STATUS, 32'h18, 1'b0);
        rdchk(slp_pkg::ADDR_REGULATOR_CONTROL, 32'h01, 1'b0);
        rdchk(slp_pkg::ADDR_WATCHDOG_CONTROL, 32'h16, 1'b0);
        apb(1'b1, slp_pkg::ADDR_CORE_STATUS, 32'h0);
        rdchk(slp_pkg::ADDR_CORE_STATUS, 32'h18, 1'b0);
        apb(1'b1, slp_pkg::ADDR_WATCHDOG_CONTROL, 32'h3F);
        rdchk(slp_pkg::ADDR_WATCHDOG_CONTROL, 32'h3F, 1'b0);
        rdchk(8'h0C, 32'h0, 1'b1);
        // enabled flag up, gie clear: sleep is a nop
        irq_req <= 8'h01;
        sleep_go();
        chk({sleep_nop, cpu_clk_en, power_down_flag, timeout_flag}, 4'hF);
        irq_req <= 8'h00;
        foreach (ROWS[i]) begin
            r = ROWS[i];
            crystal_mode    <= r.xt;
            two_speed_start <= r.ts;
            irq_en_req      <= r.g;
            timer1_src      <= r.src;
            adc_rc_select   <= r.arc;
            d = (r.xt && !r.ts ? slp_pkg::OST_CYCLES : 0) + (r.lp ? slp_pkg::REG_STAB_CYCLES : 0);
            apb(1'b1, slp_pkg::ADDR_REGULATOR_CONTROL, {30'h0, r.lp, 1'b1});
            sleep_go();
            chk({cpu_clk_en, io_hold, power_down_flag, timeout_flag}, 4'h5);
            repeat (2) @(posedge clk);
            chk({timer1_run, adc_run, regulator_lp, lf_osc_run}, {r.src != 2'h0, r.arc, r.lp, 1'b1});
            irq_req <= 8'h80;
            repeat (8) @(posedge clk);
            chk(cpu_clk_en, 1'b0);
            irq_req <= 8'h81;
            wt(1'b0, 3000);
            chk(c, d + 3);
            chk({isr_call, cpu_clk_en, io_hold}, {r.g, 2'b10});
            irq_req <= 8'h00;
        end
        // each reset source while asleep
        for (int j = 0; j < 3; j++) begin
            sleep_go();
            ext_reset_pin_n <= (j != 0);
            brownout_reset  <= (j == 1);
            por_event       <= (j == 2);
            wt(1'b1, 20);
            chk(c < 20, 1'b1);
            ext_reset_pin_n <= 1'b1;
            brownout_reset  <= 1'b0;
            por_event       <= 1'b0;
            repeat (2) @(posedge clk);
            chk(cpu_clk_en, 1'b1);
        end
        rdchk(slp_pkg::ADDR_CORE_STATUS, 32'h18, 1'b0);
        // shortest period, counted from a clear
        apb(1'b1, slp_pkg::ADDR_WATCHDOG_CONTROL, 32'h0);
        wdt_config <= 2'h2;
        req_clr    <= 1'b1;
        @(posedge clk);
        req_clr    <= 1'b0;
        wt(1'b1, 50000);
        chk(c > 39991 && c < 41282, 1'b1);
        @(posedge clk);
        chk({power_down_flag, timeout_flag}, 2'b10);
        wdt_config <= 2'h3;
        sleep_go();
        wt(1'b0, 50000);
        chk(c - d > 39991 && c - d < 41282, 1'b1);
        chk({isr_call, power_down_flag, timeout_flag}, 3'b000);
        wdt_config <= 2'h0;
        print_verdict();
    end
    // hang guard above the run length
    initial begin
        #(120000 * 25);
        err_total++;
        print_verdict();
    end
endmodule // tb_slp_ctrl
